// *** design/rom_decode_pkg.sv ***
/*
 * shared constants for the rom/flash block decode: register addresses,
 * field positions, reset values and the size encoding.
 * assumes a 32-bit processor bus address with bit 0 of the documented
 * numbering being the most significant bit (bit 31 here).
 */
package rom_decode_pkg;
    // =====================================================================
    // register addresses (byte addresses on the axi4-lite bus)
    localparam logic [31:0] REG_A_ADDR     = 32'hFEF80050;
    localparam logic [31:0] REG_B_ADDR     = 32'hFEF80058;

    // =====================================================================
    // field positions inside a base/size register
    localparam int          BASE_HI        = 31;
    localparam int          BASE_LO        = 20;
    localparam int          WIDE_BIT       = 19;
    localparam int          SIZ_HI         = 18;
    localparam int          SIZ_LO         = 16;
    localparam int          RV_BIT         = 2;
    localparam int          EN_BIT         = 1;
    localparam int          WE_BIT         = 0;
    localparam logic [31:0] WRITABLE_MASK  = 32'hFFF70007;

    // =====================================================================
    // reset values
    localparam logic [11:0] BASE_A_RESET   = 12'hFF0;
    localparam logic [11:0] BASE_B_RESET   = 12'hFF4;

    // =====================================================================
    // size encoding and vector window
    localparam logic [2:0]  SIZ_RESERVED   = 3'h7;
    localparam logic [11:0] VEC_WINDOW     = 12'hFFF;
    localparam int          MB_BITS        = 20;
    localparam int          OFFSET_W       = 26;

    // =====================================================================
    // processor bus transfer sizes (bytes) and axi responses
    localparam logic [3:0]  XFER_BYTE      = 4'h1;
    localparam logic [3:0]  XFER_WORD      = 4'h4;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ROUTE_NONE,
        ROUTE_A,
        ROUTE_B
    } route_t;
endpackage

// *** design/rom_block_match.sv ***
/*
 * address match for one rom/flash block: base compare masked by size,
 * plus the optional reset-vector window hit.
 * assumes the caller supplies the vector routing decision.
 */
`timescale 1ns/1ps
module rom_block_match
    import rom_decode_pkg::*;
(
    input  wire logic [31:0]         addr,      // processor bus address
    input  wire logic [11:0]         base,      // programmed base field
    input  wire logic [2:0]          siz,       // size code
    input  wire logic                en,        // access enable
    input  wire logic                vec_sel,   // window routed to this block
    output logic                     hit,       // block selected
    output logic [OFFSET_W-1:0]      offset     // byte offset inside block
);
    logic [11:0] mask;
    logic        in_window;

    // size code turns into a mask of ignored low base bits
    always_comb begin
        mask = 12'hFFF << siz;
    end

    assign in_window = (addr[BASE_HI:BASE_LO] == VEC_WINDOW);

    // vector window first, then the programmed range
    always_comb begin
        if (in_window && vec_sel) begin
            hit    = 1'b1;
            offset = {{(OFFSET_W-MB_BITS){1'b0}}, addr[MB_BITS-1:0]};
        end else begin
            hit    = en && (siz != SIZ_RESERVED)
                     && ((addr[BASE_HI:BASE_LO] & mask) == (base & mask));
            offset = addr[OFFSET_W-1:0] & {~mask[5:0], {MB_BITS{1'b1}}};
        end
    end
endmodule

// *** design/rom_flash_decode.sv ***
/*
 * rom/flash block a and b decode and access control with an axi4-lite
 * slave holding the two base/size registers.
 * assumes processor bus requests are one-cycle pulses synchronous to aclk
 * and straps are stable while aresetn is low.
 */
// What this block does
// - base field bits compare to address bits 0..11 to select a block
// - sizes above 1MB ignore low base bits, block aligns to its size
// - reset loads base a with FF0 and base b with FF4
// - width flag clear means 8-bit block, set means 64-bit block
// - width flag captured from strap at reset, read only to software
// - size code 000..110 gives 1MB..64MB, 111 is reserved
// - vector window routes by select bits: 00 none, 10 a, x1 b
// - block a vector select preset from its strap at reset
// - block a range answers only while its access enable is set
// - block a memory is written only while its write enable is set
// - only byte writes to narrow, aligned word writes to wide blocks
// - valid write with write enable clear ends normally, reads end normally
// - block b vector select also maps its first 1MB at the window
// - block b vector select preset from its strap at reset
// - block b access and write enables gate as for block a
`timescale 1ns/1ps
module rom_flash_decode
    import rom_decode_pkg::*;
#(
    parameter int ADDR_W = 32                        // bus address width
)(
    input  wire logic                aclk,           // clock, 250 MHz
    input  wire logic                aresetn,        // sync reset, low
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,   // write address
    input  wire logic                s_axi_awvalid,  // write address valid
    output logic                     s_axi_awready,  // write address ready
    input  wire logic [31:0]         s_axi_wdata,    // write data
    input  wire logic [3:0]          s_axi_wstrb,    // byte strobes
    input  wire logic                s_axi_wvalid,   // write data valid
    output logic                     s_axi_wready,   // write data ready
    output logic [1:0]               s_axi_bresp,    // write response
    output logic                     s_axi_bvalid,   // write response valid
    input  wire logic                s_axi_bready,   // write response ready
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,   // read address
    input  wire logic                s_axi_arvalid,  // read address valid
    output logic                     s_axi_arready,  // read address ready
    output logic [31:0]              s_axi_rdata,    // read data
    output logic [1:0]               s_axi_rresp,    // read response
    output logic                     s_axi_rvalid,   // read data valid
    input  wire logic                s_axi_rready,   // read data ready
    // straps
    input  wire logic                strap_vector_a_pin, // a vector select
    input  wire logic                strap_vector_b_pin, // b vector select
    input  wire logic                strap_width_a_pin,  // a is 64-bit
    input  wire logic                strap_width_b_pin,  // b is 64-bit
    // processor bus request
    input  wire logic                pb_valid,       // request pulse
    input  wire logic [31:0]         pb_addr,        // request address
    input  wire logic                pb_write,       // 1 write, 0 read
    input  wire logic [3:0]          pb_size,        // transfer bytes
    output logic                     pb_ack_q,       // normal termination
    // rom/flash side
    output logic                     rom_a_cs_q,     // block a cycle
    output logic                     rom_b_cs_q,     // block b cycle
    output logic                     rom_write_q,    // memory is written
    output logic                     rom_wide_q,     // 64-bit block
    output logic [OFFSET_W-1:0]      rom_offset_q    // offset in block
);
    // =====================================================================
    // elaboration check
    if (ADDR_W != 32) begin : g_addr_w_check
        $error("ADDR_W must be 32");
    end

    // =====================================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return (r & WRITABLE_MASK) | (old_v & ~WRITABLE_MASK);
    endfunction

    function automatic logic [31:0] pack(input logic [11:0] base, input logic wide,
                                         input logic [2:0] siz, input logic rv,
                                         input logic en, input logic we);
        logic [31:0] r;
        r = 32'h00000000;
        r[BASE_HI:BASE_LO] = base;
        r[WIDE_BIT]        = wide;
        r[SIZ_HI:SIZ_LO]   = siz;
        r[RV_BIT]          = rv;
        r[EN_BIT]          = en;
        r[WE_BIT]          = we;
        return r;
    endfunction

    // =====================================================================
    // register state
    logic [11:0] base_a_q, base_b_q;
    logic [2:0]  siz_a_q, siz_b_q;
    logic        wide_a_q, wide_b_q;
    logic        rv_a_q, rv_b_q, en_a_q, en_b_q, we_a_q, we_b_q;
    logic [31:0] reg_a, reg_b, new_a, new_b;

    assign reg_a = pack(base_a_q, wide_a_q, siz_a_q, rv_a_q, en_a_q, we_a_q);
    assign reg_b = pack(base_b_q, wide_b_q, siz_b_q, rv_b_q, en_b_q, we_b_q);

    // =====================================================================
    // axi write channel
    logic [31:0] awaddr_q, wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have_q, w_have_q, do_write;

    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign new_a    = merge(reg_a, wdata_q, wstrb_q);
    assign new_b    = merge(reg_b, wdata_q, wstrb_q);

    // write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_have_q     <= 1'b0;
            awaddr_q      <= 32'h00000000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q     <= 1'b0;
        end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_have_q     <= 1'b0;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q     <= 1'b0;
        end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == REG_A_ADDR || awaddr_q == REG_B_ADDR) ?
                            RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // block a register, straps caught while reset is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_a_q <= BASE_A_RESET;
            wide_a_q <= strap_width_a_pin;
            siz_a_q  <= 3'h0;
            rv_a_q   <= strap_vector_a_pin;
            en_a_q   <= 1'b0;
            we_a_q   <= 1'b0;
        end else if (do_write && awaddr_q == REG_A_ADDR) begin
            base_a_q <= new_a[BASE_HI:BASE_LO];
            siz_a_q  <= new_a[SIZ_HI:SIZ_LO];
            rv_a_q   <= new_a[RV_BIT];
            en_a_q   <= new_a[EN_BIT];
            we_a_q   <= new_a[WE_BIT];
        end
    end

    // block b register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_b_q <= BASE_B_RESET;
            wide_b_q <= strap_width_b_pin;
            siz_b_q  <= 3'h0;
            rv_b_q   <= strap_vector_b_pin;
            en_b_q   <= 1'b0;
            we_b_q   <= 1'b0;
        end else if (do_write && awaddr_q == REG_B_ADDR) begin
            base_b_q <= new_b[BASE_HI:BASE_LO];
            siz_b_q  <= new_b[SIZ_HI:SIZ_LO];
            rv_b_q   <= new_b[RV_BIT];
            en_b_q   <= new_b[EN_BIT];
            we_b_q   <= new_b[WE_BIT];
        end
    end

    // =====================================================================
    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            if (s_axi_araddr == REG_A_ADDR) begin
                s_axi_rdata <= reg_a;
            end else if (s_axi_araddr == REG_B_ADDR) begin
                s_axi_rdata <= reg_b;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // =====================================================================
    // vector window routing
    route_t route;
    always_comb begin
        case ({rv_a_q, rv_b_q})
            2'b10:   route = ROUTE_A;
            2'b01:   route = ROUTE_B;
            2'b11:   route = ROUTE_B;
            default: route = ROUTE_NONE;
        endcase
    end

    // =====================================================================
    // per-block address match
    logic                hit_a, hit_b;
    logic [OFFSET_W-1:0] off_a, off_b;

    rom_block_match u_match_a (
        .addr    (pb_addr),
        .base    (base_a_q),
        .siz     (siz_a_q),
        .en      (en_a_q),
        .vec_sel (route == ROUTE_A),
        .hit     (hit_a),
        .offset  (off_a)
    );

    rom_block_match u_match_b (
        .addr    (pb_addr),
        .base    (base_b_q),
        .siz     (siz_b_q),
        .en      (en_b_q),
        .vec_sel (route == ROUTE_B),
        .hit     (hit_b),
        .offset  (off_b)
    );

    // =====================================================================
    // access control: block a wins a misprogrammed overlap
    logic sel_a, sel_b, wide, we_ok, size_ok;
    assign sel_a = hit_a;
    assign sel_b = hit_b && !hit_a;
    assign wide  = sel_a ? wide_a_q : wide_b_q;
    assign we_ok = sel_a ? we_a_q : we_b_q;

    // legal write sizes per block width
    always_comb begin
        if (wide) begin
            size_ok = (pb_size == XFER_WORD) && (pb_addr[1:0] == 2'h0);
        end else begin
            size_ok = (pb_size == XFER_BYTE);
        end
    end

    // one-cycle termination and memory strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_ack_q     <= 1'b0;
            rom_a_cs_q   <= 1'b0;
            rom_b_cs_q   <= 1'b0;
            rom_write_q  <= 1'b0;
            rom_wide_q   <= 1'b0;
            rom_offset_q <= '0;
        end else begin
            pb_ack_q     <= 1'b0;
            rom_a_cs_q   <= 1'b0;
            rom_b_cs_q   <= 1'b0;
            rom_write_q  <= 1'b0;
            if (pb_valid && (sel_a || sel_b) && (!pb_write || size_ok)) begin
                pb_ack_q     <= 1'b1;
                rom_a_cs_q   <= sel_a;
                rom_b_cs_q   <= sel_b;
                rom_write_q  <= pb_write && we_ok;
                rom_wide_q   <= wide;
                rom_offset_q <= sel_a ? off_a : off_b;
            end
        end
    end
endmodule

// *** test/rom_flash_decode_sva.sv ***
/* port checker for the rom/flash decode.
   assumes one clock aclk and a sync active-low aresetn. */
`timescale 1ns/1ps
module rom_flash_decode_sva
    import rom_decode_pkg::*;
(
    input wire logic                aclk,         // clock
    input wire logic                aresetn,      // sync reset
    input wire logic [31:0]         s_axi_rdata,  // read data
    input wire logic                s_axi_rvalid, // read valid
    input wire logic                pb_valid,     // request
    input wire logic [31:0]         pb_addr,      // address
    input wire logic                pb_write,     // write
    input wire logic [3:0]          pb_size,      // bytes
    input wire logic                pb_ack_q,     // ack
    input wire logic                rom_a_cs_q,   // block a
    input wire logic                rom_b_cs_q,   // block b
    input wire logic                rom_write_q,  // written
    input wire logic                rom_wide_q,   // wide block
    input wire logic [OFFSET_W-1:0] rom_offset_q  // offset
);
    // ==========================================
    // processor bus and register read checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ack_cause: assert property (pb_ack_q |-> $past(pb_valid))
        else $error("ack without request");
    a_one_block: assert property (pb_ack_q |-> rom_a_cs_q != rom_b_cs_q)
        else $error("ack must select exactly one block");
    a_cs_with_ack: assert property ((rom_a_cs_q || rom_b_cs_q || rom_write_q) |-> pb_ack_q)
        else $error("block strobe without ack");
    a_write_cause: assert property (rom_write_q |-> $past(pb_write))
        else $error("memory written on a read");
    a_bad_size: assert property (pb_valid && pb_write && pb_size != XFER_BYTE
        && pb_size != XFER_WORD |=> !pb_ack_q) else $error("odd write size acked");
    a_narrow_byte: assert property (pb_ack_q && !rom_wide_q && $past(pb_write)
        |-> $past(pb_size) == XFER_BYTE) else $error("narrow write not a byte");
    a_wide_word: assert property (pb_ack_q && rom_wide_q && $past(pb_write)
        |-> $past(pb_size) == XFER_WORD && ($past(pb_addr) & 32'h3) == 32'h0)
        else $error("wide write not an aligned word");
    a_offset_low: assert property (pb_ack_q |-> {12'h000, rom_offset_q[19:0]}
        == ($past(pb_addr) & 32'h000FFFFF)) else $error("offset low bits wrong");
    a_unused_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'h0000FFF8) == 32'h0)
        else $error("unused register bits not zero");
endmodule

bind rom_flash_decode rom_flash_decode_sva i_sva (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid,
    .pb_valid, .pb_addr, .pb_write, .pb_size, .pb_ack_q, .rom_a_cs_q, .rom_b_cs_q,
    .rom_write_q, .rom_wide_q, .rom_offset_q);

// *** test/rom_model.sv ***
/* rom/flash device model: counts memory writes per block.
   assumes the decode strobes are one-cycle pulses on aclk. */
`timescale 1ns/1ps
module rom_model (
    input wire logic    aclk, // clock
    input wire logic    cs_a, // block a cycle
    input wire logic    cs_b, // block b cycle
    input wire logic    wr,   // memory write
    output int unsigned wr_a, // writes to a
    output int unsigned wr_b  // writes to b
);
    // ==========================================
    // write counting
    initial begin
        wr_a = 0;
        wr_b = 0;
    end
    always @(posedge aclk) begin
        if (wr && cs_a) wr_a <= wr_a + 1;
        if (wr && cs_b) wr_b <= wr_b + 1;
    end
endmodule

// *** test/rom_flash_block_decode_bench.sv ***
/* self-checking bench for rom_flash_decode with a rom write model.
   assumes the checker is bound through its own file. */
`timescale 1ns/1ps
module rom_flash_block_decode_bench;
    import rom_decode_pkg::*;
    logic                aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic                s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                s_axi_rvalid, pb_valid, pb_write, pb_ack_q, rom_a_cs_q, rom_b_cs_q;
    logic                rom_write_q, rom_wide_q, strap_vector_a_pin, strap_vector_b_pin;
    logic                strap_width_a_pin, strap_width_b_pin;
    logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, pb_addr, rd_v;
    logic [3:0]          s_axi_wstrb, pb_size;
    logic [1:0]          s_axi_bresp, s_axi_rresp, resp;
    logic [OFFSET_W-1:0] rom_offset_q;
    int                  fails, samples_checked;
    int                  cycles = 0;
    int unsigned         wr_a, wr_b;

    rom_flash_decode i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .strap_vector_a_pin, .strap_vector_b_pin, .strap_width_a_pin,
        .strap_width_b_pin, .pb_valid, .pb_addr, .pb_write, .pb_size, .pb_ack_q, .rom_a_cs_q,
        .rom_b_cs_q, .rom_write_q, .rom_wide_q, .rom_offset_q);
    rom_model i_rom (.aclk, .cs_a(rom_a_cs_q), .cs_b(rom_b_cs_q), .wr(rom_write_q), .wr_a, .wr_b);

    // ==========================================
    // clock and hang guard
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            final_report;
        end
    end

    // ==========================================
    // helpers
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] regv(input logic [11:0] b, input logic [2:0] s, input logic [2:0] c);
        return {b, 1'h0, s, 13'h0000, c}; // c is vector select, enable, write enable
    endfunction
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        @(posedge aclk);
        while (!s_axi_rvalid) @(posedge aclk);
        rd_v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic set_reg(input logic [31:0] a, input logic [31:0] d);
        repeat (2) axi_rd(REG_B_ADDR);
        axi_wr(a, d);
        repeat (2) axi_rd(REG_B_ADDR);
    endtask
    // exp is {ack, block a, block b, written}
    task automatic pb(input logic [31:0] a, input logic w, input logic [3:0] sz, input logic [3:0] exp,
                      input logic [31:0] off);
        @(posedge aclk);
        pb_addr <= a;
        pb_write <= w;
        pb_size <= sz;
        pb_valid <= 1'h1;
        @(posedge aclk);
        pb_valid <= 1'h0;
        #1;
        chk("ack_cs_write", {28'h0, exp}, {28'h0, pb_ack_q, rom_a_cs_q, rom_b_cs_q, rom_write_q});
        if (exp[3]) chk("offset", off, {6'h00, rom_offset_q});
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs;
        axi_rd(REG_A_ADDR);
        chk("reg_a_reset", 32'hFF000004, rd_v);
        axi_rd(REG_B_ADDR);
        chk("reg_b_reset", 32'hFF480000, rd_v);
        axi_wr(REG_A_ADDR, 32'hFFFFFFFF);
        axi_rd(REG_A_ADDR);
        chk("reg_a_ones", 32'hFFF70007, rd_v);
        axi_wr(REG_B_ADDR, 32'h00000000);
        axi_rd(REG_B_ADDR);
        chk("reg_b_zero", 32'h00080000, rd_v);
        axi_wr(32'hFEF80054, 32'h12345678);
        chk("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        axi_rd(32'hFEF80054);
        chk("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test registers done");
    endtask
    task automatic t_vector;
        for (int i = 0; i < 4; i++) begin
            set_reg(REG_A_ADDR, regv(12'hFF0, 3'h0, {i[1], 2'h0}));
            set_reg(REG_B_ADDR, regv(12'hFF4, 3'h0, {i[0], 2'h0}));
            pb(32'hFFF00010 + i, 1'h0, XFER_WORD, (i == 0) ? 4'h0 : (i == 2) ? 4'hC : 4'hA, 32'h10 + i);
        end
        pb(32'hFF400020, 1'h0, XFER_WORD, 4'h0, 32'h0);
        $display("test vector done");
    endtask
    task automatic t_enable;
        set_reg(REG_A_ADDR, regv(12'hFF0, 3'h0, 3'h0));
        pb(32'hFF000100, 1'h0, XFER_BYTE, 4'h0, 32'h0);
        set_reg(REG_A_ADDR, regv(12'hFF0, 3'h0, 3'h2));
        pb(32'hFF000100, 1'h0, XFER_BYTE, 4'hC, 32'h100);
        pb(32'hFF100100, 1'h0, XFER_BYTE, 4'h0, 32'h0);
        set_reg(REG_B_ADDR, regv(12'hFF4, 3'h0, 3'h2));
        pb(32'hFF4FFFFC, 1'h0, XFER_WORD, 4'hA, 32'hFFFFC);
        $display("test enable done");
    endtask
    task automatic t_size;
        logic [31:0] sz;
        for (int s = 0; s < 8; s++) begin
            sz = 32'h1 << (20 + s);
            set_reg(REG_A_ADDR, regv(12'h080 + 12'((1 << s) - 1), s[2:0], 3'h2));
            if (s < 7) begin
                pb(32'h08000000 + sz - 4, 1'h0, XFER_WORD, 4'hC, sz - 4);
                pb(32'h08000000 + sz, 1'h0, XFER_WORD, 4'h0, 32'h0);
            end else
                pb(32'h08000000, 1'h0, XFER_WORD, 4'h0, 32'h0);
        end
        $display("test size done");
    endtask
    task automatic t_writes;
        set_reg(REG_A_ADDR, regv(12'hFF0, 3'h0, 3'h2));
        set_reg(REG_B_ADDR, regv(12'h0C0, 3'h0, 3'h2));
        for (int n = 1; n < 9; n++)
            pb(32'hFF000040, 1'h1, n[3:0], (n == 1) ? 4'hC : 4'h0, 32'h40);
        set_reg(REG_A_ADDR, regv(12'hFF0, 3'h0, 3'h3));
        pb(32'hFF000041, 1'h1, XFER_BYTE, 4'hD, 32'h41);
        chk("wide_a", 32'h0, {31'h0, rom_wide_q});
        for (int n = 1; n < 9; n++)
            pb(32'h0C000080, 1'h1, n[3:0], (n == 4) ? 4'hA : 4'h0, 32'h80);
        chk("wide_b", 32'h1, {31'h0, rom_wide_q});
        set_reg(REG_B_ADDR, regv(12'h0C0, 3'h0, 3'h3));
        pb(32'h0C000084, 1'h1, XFER_WORD, 4'hB, 32'h84);
        pb(32'h0C000086, 1'h1, XFER_WORD, 4'h0, 32'h0);
        pb(32'h0C000088, 1'h0, 4'h2, 4'hA, 32'h88);
        chk("writes_a", 32'h1, wr_a);
        chk("writes_b", 32'h1, wr_b);
        $display("test writes done");
    endtask

    // ==========================================
    // main sequence
    initial begin
        fails = 0;
        samples_checked = 0;
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pb_valid, pb_write} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, pb_addr, pb_size} = '0;
        s_axi_wstrb = 4'hF;
        {strap_vector_a_pin, strap_vector_b_pin, strap_width_a_pin, strap_width_b_pin} = 4'h9;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_vector;
        t_enable;
        t_size;
        t_writes;
        final_report;
    end
endmodule
